// ### inc/baud_gen_pkg.sv
// Constants and types shared by the bit-rate generator
package baud_gen_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int DATA_W = 32;
    localparam int ADR_W  = 12;
    localparam int IDX_W  = 10;
    // Register indexes; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_FRAC   = 10'h09d;
    localparam logic [IDX_W-1:0] IDX_CTRL   = 10'h09e;
    localparam logic [IDX_W-1:0] IDX_WTCON  = 10'h0a0;
    localparam logic [IDX_W-1:0] IDX_PWR    = 10'h0a1;
    localparam logic [IDX_W-1:0] IDX_RLD_LO = 10'h0a2;
    localparam logic [IDX_W-1:0] IDX_RLD_HI = 10'h0a3;
    localparam logic [IDX_W-1:0] IDX_CNT_LO = 10'h0a4;
    localparam logic [IDX_W-1:0] IDX_CNT_HI = 10'h0a5;
    localparam logic [IDX_W-1:0] IDX_STATUS = 10'h0a6;
    // Field positions and widths
    localparam int CTRL_EN_BIT  = 7;
    localparam int DIV_W        = 3;
    localparam int FRAC_W       = 6;
    localparam int WTC_TX_BIT   = 5;
    localparam int WTC_RX_BIT   = 4;
    localparam int WTC_RUN_BIT  = 2;
    localparam int PWR_DBL_BIT  = 7;
    // Reset values
    localparam logic [7:0] CTRL_RST  = 8'h00;
    localparam logic [5:0] FRAC_RST  = 6'h00;
    localparam logic [7:0] WTC_RST   = 8'h00;
    localparam logic [7:0] PWR_RST   = 8'h00;
    localparam logic [7:0] RLD_RST   = 8'h00;
    // Divider figures
    localparam logic [DIV_W-1:0] DIV_MAX   = 3'h6;
    localparam logic [6:0]       FRAC_BASE = 7'h40;
    localparam logic [15:0]      WIDE_TOP  = 16'hffff;
    localparam logic [3:0]       OVS_LAST  = 4'hf;
    typedef enum {
        SRC_SLOW,
        SRC_WIDE,
        SRC_DEDICATED
    } source_t;
endpackage

// ### inc/baud_cfg_if.sv
// Configuration and tick link to the dedicated divider
`timescale 1ns/1ps
`default_nettype none
interface baud_cfg_if;
    logic       enable;
    logic [2:0] div_code;
    logic [5:0] frac;
    logic       sample_tick;
    modport ctrl (
        output enable,
        output div_code,
        output frac,
        input  sample_tick
    );
    modport divider (
        input  enable,
        input  div_code,
        input  frac,
        output sample_tick
    );
endinterface
`default_nettype wire

// ### hw/fractional_baud_divider.sv
// Dedicated binary plus fractional divider, 16x sample ticks
`timescale 1ns/1ps
`default_nettype none
module fractional_baud_divider (
    input  wire logic clk_i,
    input  wire logic rst_i,
    baud_cfg_if.divider cfg
);
    logic [13:0] acc;
    logic [13:0] modulus;
    logic [13:0] acc_step;
    logic [2:0]  div_eff;

    // Codes above six act as six
    always_comb begin
        div_eff = (cfg.div_code > baud_gen_pkg::DIV_MAX) ?
                  baud_gen_pkg::DIV_MAX : cfg.div_code;
        modulus = 14'({1'b0, cfg.frac} + baud_gen_pkg::FRAC_BASE)
                  << div_eff;
        acc_step = acc + 14'(baud_gen_pkg::FRAC_BASE);
    end

    // Mean tick period is modulus/64 cycles
    always_ff @(posedge clk_i) begin
        if (rst_i || !cfg.enable) begin
            acc             <= 14'h0000;
            cfg.sample_tick <= 1'b0;
        end else if (acc_step >= modulus) begin
            acc             <= acc_step - modulus;
            cfg.sample_tick <= 1'b1;
        end else begin
            acc             <= acc_step;
            cfg.sample_tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### hw/uart_baud_rate_generator.sv
// Bit-rate generator for the variable-rate serial modes
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - In baud mode the wide timer counts once per two clock cycles.
// - Wide timer bit rate is clock over 32 times (65536 minus reload).
// - Wide timer reloads from the capture pair on overflow.
// - Transmit and receive select bits each pick the wide timer.
// - Dedicated enable overrides doubling bit and both select bits.
// - Binary divider code sits in control bits 2..0, codes 0..6.
// - Fractional register keeps six bits; upper two ignore writes.
// - Dedicated rate is 2*clock/(2^(code-1)*(fraction+64)).
// - Dedicated timer covers 49213 to 6250000 bps at CLK_HZ within 0.8 percent.
// - Without dedicated timer, each direction uses slow or wide timer.
// - Slow timer rate is 2^doubling/32 times its overflow rate.
// - Wide timer overflows sixteen times per bit.
module uart_baud_rate_generator (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [11:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic             ack_o,
    output logic      [31:0] dat_o,
    input  wire logic        slow_overflow_i,
    output logic             tx_sample_tick_o,
    output logic             tx_bit_tick_o,
    output logic             rx_sample_tick_o,
    output logic             rx_bit_tick_o,
    output logic             wide_overflow_o
);
    // Software registers
    logic [7:0]  dedicated_baud_control;
    logic [5:0]  uart_fractional_divider;
    logic [7:0]  wide_timer_control;
    logic [7:0]  power_control_register;
    logic [7:0]  reload_capture_low;
    logic [7:0]  reload_capture_high;

    // Decoded fields
    logic        dedicated_baud_enable;
    logic [2:0]  binary_divider_code;
    logic        transmit_clock_select;
    logic        receive_clock_select;
    logic        wide_run;
    logic        rate_doubling_bit;
    logic [15:0] reload_value;

    // Bus decode
    logic             wb_req;
    logic             wb_wr;
    logic [9:0]       wb_idx;
    logic [31:0]      next_dat;

    // Wide timer state
    logic [15:0] wide_count;
    logic        wide_half;
    logic        wide_baud;
    logic        wide_ovf;

    // Slow timer prescale
    logic        slow_half;
    logic        slow_sample;

    // Per-direction sample events and sources
    logic [1:0]  wide_pick;
    logic [1:0]  sample_ev;
    logic [1:0]  sample_q;
    logic [1:0]  bit_q;
    logic [3:0]  ovs_count [2];
    baud_gen_pkg::source_t src [2];

    // Source seen last cycle, per direction
    baud_gen_pkg::source_t src_prev [2];
    logic [1:0]  src_moved;

    baud_cfg_if cfg ();

    assign dedicated_baud_enable =
        dedicated_baud_control[baud_gen_pkg::CTRL_EN_BIT];
    assign binary_divider_code =
        dedicated_baud_control[baud_gen_pkg::DIV_W-1:0];
    assign transmit_clock_select =
        wide_timer_control[baud_gen_pkg::WTC_TX_BIT];
    assign receive_clock_select =
        wide_timer_control[baud_gen_pkg::WTC_RX_BIT];
    assign wide_run =
        wide_timer_control[baud_gen_pkg::WTC_RUN_BIT];
    assign rate_doubling_bit =
        power_control_register[baud_gen_pkg::PWR_DBL_BIT];
    assign reload_value = {reload_capture_high, reload_capture_low};

    // Dedicated divider configuration
    assign cfg.enable   = dedicated_baud_enable;
    assign cfg.div_code = binary_divider_code;
    assign cfg.frac     = uart_fractional_divider;

    fractional_baud_divider u_frac (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .cfg   (cfg)
    );

    // Classic bus handshake, one wait state
    assign wb_req = cyc_i & stb_i & ~ack_o;
    assign wb_wr  = wb_req & we_i & sel_i[0];
    assign wb_idx = adr_i[11:2];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= wb_req;
        end
    end

    // Read multiplexer, unmapped reads as zero
    always_comb begin
        next_dat = 32'h0000_0000;
        case (wb_idx)
            baud_gen_pkg::IDX_CTRL: begin
                next_dat[7] = dedicated_baud_control[7];
                next_dat[2:0] = dedicated_baud_control[2:0];
            end
            baud_gen_pkg::IDX_FRAC: begin
                next_dat[5:0] = uart_fractional_divider;
            end
            baud_gen_pkg::IDX_WTCON: begin
                next_dat[7:0] = wide_timer_control;
            end
            baud_gen_pkg::IDX_PWR: begin
                next_dat[7:0] = power_control_register;
            end
            baud_gen_pkg::IDX_RLD_LO: begin
                next_dat[7:0] = reload_capture_low;
            end
            baud_gen_pkg::IDX_RLD_HI: begin
                next_dat[7:0] = reload_capture_high;
            end
            baud_gen_pkg::IDX_CNT_LO: begin
                next_dat[7:0] = wide_count[7:0];
            end
            baud_gen_pkg::IDX_CNT_HI: begin
                next_dat[7:0] = wide_count[15:8];
            end
            baud_gen_pkg::IDX_STATUS: begin
                next_dat[0] = wide_baud;
                next_dat[1] = dedicated_baud_enable;
                next_dat[2] = wide_pick[0];
                next_dat[3] = wide_pick[1];
                // Directions running from the dedicated divider
                next_dat[4] = (src[0] == baud_gen_pkg::SRC_DEDICATED);
                next_dat[5] = (src[1] == baud_gen_pkg::SRC_DEDICATED);
            end
            default: begin
                next_dat = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (wb_req && !we_i) begin
            dat_o <= next_dat;
        end
    end

    // Dedicated control register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dedicated_baud_control <= baud_gen_pkg::CTRL_RST;
        end else if (wb_wr && wb_idx == baud_gen_pkg::IDX_CTRL) begin
            dedicated_baud_control <= dat_i[7:0];
        end
    end

    // Fractional divider, upper bits dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            uart_fractional_divider <= baud_gen_pkg::FRAC_RST;
        end else if (wb_wr && wb_idx == baud_gen_pkg::IDX_FRAC) begin
            uart_fractional_divider <= dat_i[5:0];
        end
    end

    // Wide timer control
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wide_timer_control <= baud_gen_pkg::WTC_RST;
        end else if (wb_wr && wb_idx == baud_gen_pkg::IDX_WTCON) begin
            wide_timer_control <= dat_i[7:0];
        end
    end

    // Power control holding the doubling bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            power_control_register <= baud_gen_pkg::PWR_RST;
        end else if (wb_wr && wb_idx == baud_gen_pkg::IDX_PWR) begin
            power_control_register <= dat_i[7:0];
        end
    end

    // Capture pair
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reload_capture_low  <= baud_gen_pkg::RLD_RST;
            reload_capture_high <= baud_gen_pkg::RLD_RST;
        end else if (wb_wr) begin
            if (wb_idx == baud_gen_pkg::IDX_RLD_LO) begin
                reload_capture_low <= dat_i[7:0];
            end
            if (wb_idx == baud_gen_pkg::IDX_RLD_HI) begin
                reload_capture_high <= dat_i[7:0];
            end
        end
    end

    // Wide timer joins baud duty only while not overridden
    always_comb begin
        wide_pick[0] = transmit_clock_select
                       & ~dedicated_baud_enable;
        wide_pick[1] = receive_clock_select
                       & ~dedicated_baud_enable;
        wide_baud = (wide_pick[0] | wide_pick[1]) & wide_run;
    end

    // Half-rate count enable
    always_ff @(posedge clk_i) begin
        if (rst_i || !wide_baud) begin
            wide_half <= 1'b0;
        end else begin
            wide_half <= ~wide_half;
        end
    end

    // Sixteen-bit count with autoreload
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wide_count <= 16'h0000;
            wide_ovf   <= 1'b0;
        end else if (wb_wr && wb_idx == baud_gen_pkg::IDX_CNT_LO) begin
            // Software preset wins over counting
            wide_count[7:0] <= dat_i[7:0];
            wide_ovf        <= 1'b0;
        end else if (wb_wr && wb_idx == baud_gen_pkg::IDX_CNT_HI) begin
            wide_count[15:8] <= dat_i[7:0];
            wide_ovf         <= 1'b0;
        end else if (wide_baud && wide_half) begin
            if (wide_count == baud_gen_pkg::WIDE_TOP) begin
                wide_count <= reload_value;
                wide_ovf   <= 1'b1;
            end else begin
                wide_count <= wide_count + 16'h0001;
                wide_ovf   <= 1'b0;
            end
        end else begin
            wide_ovf <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wide_overflow_o <= 1'b0;
        end else begin
            wide_overflow_o <= wide_ovf;
        end
    end

    // Slow timer overflows halved unless doubled
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slow_half <= 1'b0;
        end else if (slow_overflow_i) begin
            slow_half <= ~slow_half;
        end
    end

    assign slow_sample = slow_overflow_i
                         & (rate_doubling_bit | slow_half);

    // Per-direction source choice and bit timing
    for (genvar ch = 0; ch < 2; ch++) begin : g_dir
        always_comb begin
            if (dedicated_baud_enable) begin
                src[ch]       = baud_gen_pkg::SRC_DEDICATED;
                sample_ev[ch] = cfg.sample_tick;
            end else if (wide_pick[ch]) begin
                src[ch]       = baud_gen_pkg::SRC_WIDE;
                sample_ev[ch] = wide_ovf;
            end else begin
                src[ch]       = baud_gen_pkg::SRC_SLOW;
                sample_ev[ch] = slow_sample;
            end
            src_moved[ch] = (src[ch] != src_prev[ch]);
        end

        // A source change restarts the bit phase
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                src_prev[ch] <= baud_gen_pkg::SRC_SLOW;
            end else begin
                src_prev[ch] <= src[ch];
            end
        end

        // Sixteen samples make one bit
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                ovs_count[ch] <= 4'h0;
                sample_q[ch]  <= 1'b0;
                bit_q[ch]     <= 1'b0;
            end else begin
                sample_q[ch] <= sample_ev[ch];
                bit_q[ch]    <= 1'b0;
                if (src_moved[ch]) begin
                    ovs_count[ch] <= 4'h0;
                end else if (sample_ev[ch]) begin
                    ovs_count[ch] <= ovs_count[ch] + 4'h1;
                    if (ovs_count[ch] == baud_gen_pkg::OVS_LAST) begin
                        bit_q[ch] <= 1'b1;
                    end
                end
            end
        end
    end

    // Outputs straight from flip-flops
    always_comb begin
        tx_sample_tick_o = sample_q[0];
        tx_bit_tick_o    = bit_q[0];
        rx_sample_tick_o = sample_q[1];
        rx_bit_tick_o    = bit_q[1];
    end
endmodule
`default_nettype wire

// ### sim/baud_gen_asserts.sv
// Port-level checks for the bit-rate generator
`timescale 1ns/1ps
`default_nettype none
module baud_gen_checker (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [11:0] adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic        ack_o,
    input wire logic [31:0] dat_o,
    input wire logic        slow_overflow_i,
    input wire logic        tx_sample_tick_o,
    input wire logic        tx_bit_tick_o,
    input wire logic        rx_sample_tick_o,
    input wire logic        rx_bit_tick_o,
    input wire logic        wide_overflow_o
);
    logic ded;
    wire logic take = cyc_i && stb_i && !ack_o;
    // Shadow of the dedicated enable bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ded <= 1'b0;
        end else if (take && we_i && sel_i[0]
                     && adr_i[11:2] == baud_gen_pkg::IDX_CTRL) begin
            ded <= dat_i[baud_gen_pkg::CTRL_EN_BIT];
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    ack_answer_a: assert property (
        take |=> ack_o) else $error("ack missing after request");
    ack_pulse_a: assert property (
        ack_o |=> !ack_o) else $error("ack longer than one cycle");
    ctrl_resv_a: assert property (
        ack_o && !$past(we_i) && $past(adr_i[11:2]) == baud_gen_pkg::IDX_CTRL
        |-> dat_o[31:3] == 29'h0 || dat_o[31:8] == 24'h0 && dat_o[6:3] == 4'h0)
        else $error("control reserved bits not zero");
    frac_resv_a: assert property (
        ack_o && !$past(we_i) && $past(adr_i[11:2]) == baud_gen_pkg::IDX_FRAC
        |-> dat_o[31:6] == 26'h0) else $error("fraction upper bits not zero");
    tx_pair_a: assert property (
        tx_bit_tick_o |-> tx_sample_tick_o) else $error("tx bit without sample");
    rx_pair_a: assert property (
        rx_bit_tick_o |-> rx_sample_tick_o) else $error("rx bit without sample");
    wide_gap_a: assert property (
        wide_overflow_o |=> !wide_overflow_o) else $error("overflow too close");
    ded_same_a: assert property (
        ded [*4] |-> tx_sample_tick_o == rx_sample_tick_o
        && tx_bit_tick_o == rx_bit_tick_o) else $error("directions differ");
    ded_quiet_a: assert property (
        ded [*4] |-> !wide_overflow_o) else $error("wide timer runs");
endmodule
bind uart_baud_rate_generator baud_gen_checker baud_gen_checker_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .ack_o(ack_o), .dat_o(dat_o), .slow_overflow_i(slow_overflow_i),
    .tx_sample_tick_o(tx_sample_tick_o), .tx_bit_tick_o(tx_bit_tick_o),
    .rx_sample_tick_o(rx_sample_tick_o), .rx_bit_tick_o(rx_bit_tick_o),
    .wide_overflow_o(wide_overflow_o));
`default_nettype wire

// ### sim/slow_timer_model.sv
// Model of the external 8-bit timer's overflow pulses
`timescale 1ns/1ps
`default_nettype none
module slow_timer_model #(
    parameter int PERIOD = 8
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    output logic      ovf_o
);
    int cnt;
    // One-cycle overflow every PERIOD clocks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt   <= 0;
            ovf_o <= 1'b0;
        end else begin
            cnt   <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            ovf_o <= (cnt == PERIOD - 1);
        end
    end
endmodule
`default_nettype wire

// ### sim/uart_baud_rate_generator_tb.sv
// Self-checking bench for the bit-rate generator
`timescale 1ns/1ps
`default_nettype none
module uart_baud_rate_generator_tb;
    logic        clk_i, rst_i, cyc, stb, we, ack_o, ovf, wo;
    logic        txs, txb, rxs, rxb;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat, dat_o;
    logic [1:0]  mark;
    logic [7:0]  rq[$];
    int          wq[$];
    int          miscompares, samples_checked, ctx, crx, cwo, cts, crs;
    uart_baud_rate_generator uart_baud_rate_generator_i (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .ack_o(ack_o),
        .dat_o(dat_o), .slow_overflow_i(ovf), .tx_sample_tick_o(txs),
        .tx_bit_tick_o(txb), .rx_sample_tick_o(rxs), .rx_bit_tick_o(rxb),
        .wide_overflow_o(wo));
    slow_timer_model slow_timer_model_i (
        .clk_i(clk_i), .rst_i(rst_i), .ovf_o(ovf));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic end_sim;
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic hang;
        miscompares++;
        end_sim();
    endtask
    task automatic chk_rd(input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (e !== s) begin
            miscompares++;
            $display("BAD rdata exp %h got %h", e, s);
        end
    endtask
    task automatic chk_cnt(input string n, input int e, input int s);
        samples_checked++;
        if (e != s) begin
            miscompares++;
            $display("BAD %s exp %0d got %0d", n, e, s);
        end
    endtask
    // Classic single bus cycle, then one idle cycle
    task automatic wb(input logic w, input logic [9:0] ix,
                      input logic [7:0] d, input logic [7:0] e,
                      input logic s);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= {ix, 2'b00};
        dat <= {24'h0, d};
        sel <= {3'h0, s};
        n = 0;
        if (!w) rq.push_back(e);
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (ack_o !== 1'b1) hang();
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [9:0] ix, input logic [7:0] d);
        wb(1'b1, ix, d, 8'h00, 1'b1);
    endtask
    task automatic rd(input logic [9:0] ix, input logic [7:0] e);
        wb(1'b0, ix, 8'h00, e, 1'b1);
    endtask
    // Note expected tick counts over an n-cycle window
    task automatic win(input int n, input int t, input int r, input int o);
        repeat (64) @(posedge clk_i);
        wq.push_back(t);
        wq.push_back(r);
        wq.push_back(o);
        wq.push_back(16 * t);
        wq.push_back(16 * r);
        mark <= 2'b01;
        @(posedge clk_i);
        mark <= 2'b00;
        repeat (n - 1) @(posedge clk_i);
        mark <= 2'b11;
        @(posedge clk_i);
        mark <= 2'b00;
    endtask
    // Output watcher
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && we === 1'b0 && rq.size() > 0) begin
            chk_rd({24'h0, rq.pop_front()}, dat_o);
        end
        if (mark[0]) begin
            if (mark[1]) begin
                chk_cnt("tx_bits", wq.pop_front(), ctx);
                chk_cnt("rx_bits", wq.pop_front(), crx);
                chk_cnt("wide_ovf", wq.pop_front(), cwo);
                chk_cnt("tx_samples", wq.pop_front(), cts);
                chk_cnt("rx_samples", wq.pop_front(), crs);
            end
            ctx = int'(txb === 1'b1);
            crx = int'(rxb === 1'b1);
            cwo = int'(wo === 1'b1);
            cts = int'(txs === 1'b1);
            crs = int'(rxs === 1'b1);
        end else begin
            ctx += int'(txb === 1'b1);
            crx += int'(rxb === 1'b1);
            cwo += int'(wo === 1'b1);
            cts += int'(txs === 1'b1);
            crs += int'(rxs === 1'b1);
        end
    end
    initial begin
        logic [7:0] v;
        int         n;
        int         dv, f, p, e, rate;
        void'($urandom(32'he90274c1));
        rst_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 12'h000;
        sel = 4'h0;
        dat = 32'h0;
        mark = 2'b00;
        miscompares = 0;
        samples_checked = 0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(baud_gen_pkg::IDX_FRAC, 8'h00);
        rd(baud_gen_pkg::IDX_CTRL, 8'h00);
        v = 8'($urandom) | 8'hc0;
        wr(baud_gen_pkg::IDX_FRAC, v);
        wb(1'b1, baud_gen_pkg::IDX_FRAC, 8'h00, 8'h00, 1'b0);
        rd(baud_gen_pkg::IDX_FRAC, {2'b00, v[5:0]});
        wr(baud_gen_pkg::IDX_CTRL, 8'h7b);
        rd(baud_gen_pkg::IDX_CTRL, 8'h03);
        wr(10'h0ff, 8'h55);
        rd(10'h0ff, 8'h00);
        wr(baud_gen_pkg::IDX_FRAC, 8'h00);
        wr(baud_gen_pkg::IDX_RLD_LO, 8'hf0);
        wr(baud_gen_pkg::IDX_RLD_HI, 8'hff);
        wr(baud_gen_pkg::IDX_CNT_LO, 8'hf0);
        wr(baud_gen_pkg::IDX_CNT_HI, 8'hff);
        rd(baud_gen_pkg::IDX_CNT_LO, 8'hf0);
        wr(baud_gen_pkg::IDX_WTCON, 8'h24);
        rd(baud_gen_pkg::IDX_STATUS, 8'h05);
        win(1024, 2, 4, 32);
        wr(baud_gen_pkg::IDX_PWR, 8'h80);
        win(1024, 2, 8, 32);
        n = 0;
        while (wo !== 1'b1 && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        if (n == 200) hang();
        win(1024, 2, 8, 32);
        wr(baud_gen_pkg::IDX_WTCON, 8'h34);
        win(1024, 2, 2, 32);
        for (int d = 0; d <= 7; d++) begin
            wr(baud_gen_pkg::IDX_CTRL, 8'h80 | 8'(d));
            win(64 << ((d > 6) ? 6 : d), 4, 4, 0);
        end
        rd(baud_gen_pkg::IDX_STATUS, 8'h32);
        rate = 2_000_000;
        dv = 0;
        while ((baud_gen_pkg::CLK_HZ / (16 * rate)) >> (dv + 1) != 0) begin
            dv++;
        end
        p = rate << dv;
        f = (4 * baud_gen_pkg::CLK_HZ + p / 2) / p - 64;
        e = (1000 * 4) / ((1 << dv) * (f + 64));
        wr(baud_gen_pkg::IDX_FRAC, 8'(f));
        wr(baud_gen_pkg::IDX_CTRL, 8'h80 | 8'(dv));
        win(1000, e, e, 0);
        end_sim();
    end
endmodule
`default_nettype wire
